/* src/independent_watchdog.sv */
/*
 Independent watchdog: 12-bit downcounter stepped by the low-speed RC
 clock through a prescaler, keyed command register, write-protected
 prescaler and reload registers, update status flags.
 Assumes the low-speed clock is a free-running pin input slower than
 clk/4, a plain register port from software, and a debug halt input.
*/
//
// Behaviour
// - 12-bit counter times out into reset
// - Key CCCC enables, stays enabled
// - Hardware option enables at power-on
// - Software enable ignored under hardware option
// - Key AAAA reloads counter
// - Key 5555 unlocks protected registers
// - Any other key relocks them
// - Prescaler codes divide by 4..256
// - 12-bit reload, reset FFF, protected
// - Status bit 1 shows reload pending
// - Status bit 0 shows prescaler pending
// - Timeout is ratio times reload+1
// - Debug halt with freeze stops counting
// - Runs on clk, stepped by synchronised low-speed edges
// - Command field 16 bits, write-only
`timescale 1ns/1ps
module independent_watchdog
#(
   parameter int CNT_WIDTH = 12
)
(
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    low_speed_rc_clock,
   input  wire logic                    hw_enable_option,
   input  wire logic                    core_halted,
   input  wire logic                    debug_halt_freeze,
   input  wire logic [3:0]              bus_addr,
   input  wire logic [31:0]             bus_wdata,
   input  wire logic                    bus_wr,
   input  wire logic                    bus_rd,
   output logic [31:0]                  bus_rdata,
   output logic                         watchdog_enabled,
   output logic [CNT_WIDTH-1:0]         counter_value,
   output logic                         system_reset_req
);
   import wdog_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   wdog_pkg::bus_req_t req;
   logic [2:0]           ls_sync_r;
   logic                 ls_tick;
   logic                 pre_tick;
   logic                 cnt_step;
   logic                 wr_cmd;
   logic                 wr_div;
   logic                 wr_rld;
   logic [15:0]          cmd_key;
   logic                 key_reload;
   logic                 key_unlock;
   logic                 key_enable;
   logic                 sw_enable;
   logic                 unlocked_r;
   logic                 enabled_r;
   logic                 hw_mode_r;
   logic                 por_seen_r;
   logic [DIV_W-1:0]     div_r;
   logic [CNT_WIDTH-1:0] rld_r;
   logic [DIV_W-1:0]     div_live_r;
   logic [CNT_WIDTH-1:0] rld_live_r;
   logic [1:0]           div_pend_r;
   logic [1:0]           rld_pend_r;
   logic [CNT_WIDTH-1:0] cnt_r;
   logic                 expired_r;
   logic                 load_cnt;
   logic                 frozen;
   logic [31:0]          rdata_nxt;
   logic [31:0]          rdata_r;

   // Register strobe decode, reused for each register
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////
   // Bus request grouping and write decode
   assign req.addr  = bus_addr;
   assign req.wdata = bus_wdata;
   assign req.wr    = bus_wr;
   assign req.rd    = bus_rd;
   assign wr_cmd    = req.wr && hit(req.addr, OFS_KEY_COMMAND);
   assign wr_div    = req.wr && hit(req.addr, OFS_PRESCALER);
   assign wr_rld    = req.wr && hit(req.addr, OFS_RELOAD);
   assign cmd_key   = req.wdata[15:0];  // Upper half ignored

   // Key decode
   assign key_reload = wr_cmd && (cmd_key == KEY_RELOAD);
   assign key_unlock = wr_cmd && (cmd_key == KEY_UNLOCK);
   assign key_enable = wr_cmd && (cmd_key == KEY_ENABLE);
   assign sw_enable  = key_enable && !hw_mode_r;

   ////////////////////////////////////////////////////////////////////////////
   // Low-speed clock: two-stage synchroniser, then rising edge detect
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         ls_sync_r <= 3'h0;
      else
         ls_sync_r <= {ls_sync_r[1:0], low_speed_rc_clock};
   end

   // Edge taken between second and third stage only
   assign ls_tick = ls_sync_r[1] && !ls_sync_r[2];

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler from the live (propagated) division code
   wdog_prescaler #(.DIV_W(DIV_W)) u_prescaler
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .clear    (load_cnt),
      .tick_in  (ls_tick && !frozen),
      .div_code (div_live_r),
      .tick_out (pre_tick)
   );

   assign frozen   = core_halted && debug_halt_freeze;
   assign cnt_step = pre_tick && enabled_r && !expired_r;

   ////////////////////////////////////////////////////////////////////////////
   // Hardware option caught at first clocked cycle after reset release
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         por_seen_r <= 1'b0;
      else
         por_seen_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         hw_mode_r <= 1'b0;
      else if (!por_seen_r)
         hw_mode_r <= hw_enable_option;
   end

   // Enable: sticky until reset, by key or by hardware option
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         enabled_r <= 1'b0;
      else if (sw_enable || (!por_seen_r && hw_enable_option))
         enabled_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write protection: unlock key opens, any other key closes
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         unlocked_r <= 1'b0;
      else if (wr_cmd)
         unlocked_r <= key_unlock;
   end

   // Software-visible prescaler and reload, written only when unlocked
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         div_r <= PRESCALER_RESET;
      else if (wr_div && unlocked_r)
         div_r <= req.wdata[DIV_W-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rld_r <= RELOAD_RESET;
      else if (wr_rld && unlocked_r)
         rld_r <= req.wdata[CNT_WIDTH-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Update propagation: pending for a set number of low-speed edges
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         div_pend_r <= 2'h0;
      else if (wr_div && unlocked_r)
         div_pend_r <= UPDATE_SLOW_EDGES;  // Set wins over the count down
      else if (ls_tick && div_pend_r != 2'h0)
         div_pend_r <= div_pend_r - 2'h1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rld_pend_r <= 2'h0;
      else if (wr_rld && unlocked_r)
         rld_pend_r <= UPDATE_SLOW_EDGES;
      else if (ls_tick && rld_pend_r != 2'h0)
         rld_pend_r <= rld_pend_r - 2'h1;
   end

   // Live copies used by the counter, taken when propagation ends
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         div_live_r <= PRESCALER_RESET;
      else if (ls_tick && div_pend_r == 2'h1)
         div_live_r <= div_r;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rld_live_r <= RELOAD_RESET;
      else if (ls_tick && rld_pend_r == 2'h1)
         rld_live_r <= rld_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Downcounter: load on enable or reload key, else step when enabled
   assign load_cnt = key_reload || sw_enable || (!enabled_r && !por_seen_r);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         cnt_r <= RELOAD_RESET;
      else if (load_cnt)
         cnt_r <= rld_live_r;
      else if (cnt_step)
         cnt_r <= cnt_r - CNT_WIDTH'(1);
   end

   // Expiry: a step from zero counts reload+1 periods
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         expired_r <= 1'b0;
      else if (cnt_step && cnt_r == '0)
         expired_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data mux, command register reads zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (hit(req.addr, OFS_PRESCALER))
         rdata_nxt = 32'(div_r);
      else if (hit(req.addr, OFS_RELOAD))
         rdata_nxt = 32'(rld_r);
      else if (hit(req.addr, OFS_STATUS))
      begin
         rdata_nxt[STS_RLD_BIT] = (rld_pend_r != 2'h0);
         rdata_nxt[STS_DIV_BIT] = (div_pend_r != 2'h0);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rdata_r <= 32'h0000_0000;
      else if (req.rd)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= 32'h0000_0000;
   end

   // Outputs
   assign bus_rdata        = rdata_r;
   assign watchdog_enabled = enabled_r;
   assign counter_value    = cnt_r;
   assign system_reset_req = expired_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_unlock_then_write;
      key_unlock ##1 wr_div;
   endsequence

   a_reset_on_expiry: assert property (@(posedge clk) disable iff (!reset_n)
      cnt_step && cnt_r == '0 |=> system_reset_req)
      else $error("no reset after zero step");
   a_enable_sticks: assert property (@(posedge clk) disable iff (!reset_n)
      key_enable |=> watchdog_enabled)
      else $error("enable key lost");
   a_enable_stays: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_enabled |=> watchdog_enabled)
      else $error("watchdog disabled itself");
   a_reload_loads: assert property (@(posedge clk) disable iff (!reset_n)
      key_reload |=> counter_value == $past(rld_live_r))
      else $error("reload key did not load");
   a_unlock_opens: assert property (@(posedge clk) disable iff (!reset_n)
      s_unlock_then_write |=> div_r == $past(req.wdata[DIV_W-1:0]))
      else $error("unlocked write not taken");
   a_other_key_locks: assert property (@(posedge clk) disable iff (!reset_n)
      wr_cmd && !key_unlock |=> !unlocked_r)
      else $error("protection not restored");
   a_locked_ignored: assert property (@(posedge clk) disable iff (!reset_n)
      wr_rld && !unlocked_r |=> $stable(rld_r))
      else $error("locked write changed reload");
   a_rld_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
      wr_rld && unlocked_r |=> rld_pend_r == UPDATE_SLOW_EDGES)
      else $error("reload pending not set");
   a_freeze_holds: assert property (@(posedge clk) disable iff (!reset_n)
      frozen && !load_cnt |=> $stable(counter_value))
      else $error("counter moved while frozen");

endmodule : independent_watchdog

/* shared/wdog_pkg.sv */
/*
 Package for the independent watchdog: register offsets, key values,
 field layouts, reset values and the low-speed tick timing.
 Assumes a single 200 MHz system clock; the low-speed clock arrives as a
 plain input pin and is sampled in that domain.
*/
package wdog_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [3:0] OFS_KEY_COMMAND = 4'h0;
   localparam logic [3:0] OFS_PRESCALER   = 4'h4;
   localparam logic [3:0] OFS_RELOAD      = 4'h8;
   localparam logic [3:0] OFS_STATUS      = 4'hC;

   // Command keys
   localparam logic [15:0] KEY_RELOAD = 16'hAAAA;
   localparam logic [15:0] KEY_UNLOCK = 16'h5555;
   localparam logic [15:0] KEY_ENABLE = 16'hCCCC;

   // Field layout and reset values
   localparam int          CNT_W           = 12;
   localparam int          DIV_W           = 3;
   localparam logic [2:0]  PRESCALER_RESET = 3'h0;
   localparam logic [11:0] RELOAD_RESET    = 12'hFFF;
   localparam int          STS_DIV_BIT     = 0;
   localparam int          STS_RLD_BIT     = 1;

   // Low-speed clock edges needed to carry a register update over
   localparam logic [1:0]  UPDATE_SLOW_EDGES = 2'h2;

   // Prescaler ratio exponent for code 000 (divide by 4) and its ceiling
   localparam logic [3:0]  DIV_BASE_LOG2 = 4'h2;
   localparam logic [3:0]  DIV_MAX_LOG2  = 4'h8;

   // Low-speed and system clock rates, for reference only
   localparam real LS_CLK_KHZ  = 40.0;
   localparam real SYS_CLK_MHZ = 200.0;

   // Bus request carried as one group
   typedef struct packed
   {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

endpackage : wdog_pkg

/* src/wdog_prescaler.sv */
/*
 Prescaler for the watchdog: turns each low-speed clock tick into a
 one-cycle count enable after 4..256 ticks, as the code selects.
 Assumes tick_in is a one-cycle pulse already in the clk domain.
*/
`timescale 1ns/1ps
module wdog_prescaler
#(
   parameter int DIV_W = 3
)
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clear,
   input  wire logic             tick_in,
   input  wire logic [DIV_W-1:0] div_code,
   output logic                  tick_out
);
   import wdog_pkg::*;

   logic [7:0] count_r;
   logic [3:0] shift_w;
   logic [7:0] limit_w;

   ////////////////////////////////////////////////////////////////////////////
   // Ratio: 4 << code, codes 6 and 7 both give 256
   assign shift_w  = (DIV_BASE_LOG2 + 4'(div_code) > DIV_MAX_LOG2) ? DIV_MAX_LOG2
                     : DIV_BASE_LOG2 + 4'(div_code);
   assign limit_w  = 8'((9'h001 << shift_w) - 9'h001);
   assign tick_out = tick_in && (count_r >= limit_w);

   // Tick counter, cleared on reload so the period restarts whole
   always_ff @(posedge clk)
   begin
      if (!reset_n || clear)
         count_r <= 8'h00;
      else if (tick_out)
         count_r <= 8'h00;
      else if (tick_in)
         count_r <= count_r + 8'h01;
   end

endmodule : wdog_prescaler

/* tb/independent_watchdog_tb_top.sv */
/*
 Self-checking bench for the independent watchdog: timeout per prescaler
 code, key commands, write protection, update flags, debug freeze.
 Assumes wdog_pkg is compiled first; the low-speed clock is made here at
 a fast rate so that timeouts stay short.
*/
`timescale 1ns/1ps
module independent_watchdog_tb_top;
   import wdog_pkg::*;

   typedef struct packed
   {
      logic [2:0]  code;
      logic [11:0] reload_field;
      logic [15:0] ticks;
   } row_t;

   logic        clk;
   logic        reset_n;
   logic        ls_clk;
   logic        hw_enable_option;
   logic        core_halted;
   logic        debug_halt_freeze;
   logic [3:0]  bus_addr;
   logic [31:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [31:0] bus_rdata;
   logic        watchdog_enabled;
   logic [11:0] counter_value;
   logic        system_reset_req;
   logic [31:0] rdv;
   logic [11:0] c0;
   int          fail_count;
   int          num_checks;
   int          cycles;
   int          ls_edges;
   int          t_exp;
   // Prescaler code, reload value, expected low-speed ticks up to the reset
   row_t        rows [8] = '{'{3'h0, 12'h000, 16'h0004}, '{3'h1, 12'h001, 16'h0010},
                             '{3'h2, 12'h001, 16'h0020}, '{3'h3, 12'h001, 16'h0040},
                             '{3'h4, 12'h001, 16'h0080}, '{3'h5, 12'h000, 16'h0080},
                             '{3'h6, 12'h000, 16'h0100}, '{3'h7, 12'h000, 16'h0100}};
   logic [3:0]  raddr [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
   logic [31:0] rexp  [5] = '{32'h0, 32'h0, 32'h0000_0FFF, 32'h0, 32'h0};

   independent_watchdog u_dut (.clk(clk), .reset_n(reset_n), .low_speed_rc_clock(ls_clk),
      .hw_enable_option(hw_enable_option), .core_halted(core_halted),
      .debug_halt_freeze(debug_halt_freeze), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .watchdog_enabled(watchdog_enabled), .counter_value(counter_value),
      .system_reset_req(system_reset_req));

   ////////////////////////////////////////////////////////////////////////////
   // Clocks, edge count of the slow clock, run limit
   always #2.5 clk = ~clk;
   always #21.3 ls_clk = ~ls_clk;
   always @(posedge ls_clk) ls_edges++;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task summarize();
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task check_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   ////////////////////////////////////////////////////////////////////////////
   // Register bus cycles
   // Full 32-bit word write
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
      #1;
   endtask : wr

   task rd(input logic [3:0] a);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1;
      rdv = bus_rdata;
   endtask : rd

   // Two writes back to back, strobe held high across both
   task wr2(input logic [3:0] a0, input logic [31:0] d0,
            input logic [3:0] a1, input logic [31:0] d1);
      @(posedge clk);
      bus_addr  <= a0;
      bus_wdata <= d0;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_addr  <= a1;
      bus_wdata <= d1;
      @(posedge clk);
      bus_wr    <= 1'b0;
      #1;
   endtask : wr2

   // Poll the status register until both update flags are clear
   task wait_idle();
      for (int i = 0; i < 100; i++)
      begin
         rd(OFS_STATUS);
         if (rdv === 32'h0)
            break;
      end
      check_val(rdv, 32'h0);
   endtask : wait_idle

   task do_reset(input logic hw);
      @(posedge clk);
      reset_n           <= 1'b0;
      hw_enable_option  <= hw;
      core_halted       <= 1'b0;
      debug_halt_freeze <= 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
   endtask : do_reset

   // Unlock and prescaler write back to back, then the reload value
   task setup(input logic [2:0] code, input logic [11:0] reload_field);
      wr2(OFS_KEY_COMMAND, {16'h0, KEY_UNLOCK}, OFS_PRESCALER, {29'h0, code});
      wr(OFS_RELOAD, {20'h0, reload_field});
      wait_idle();
      rd(OFS_PRESCALER);
      check_val(rdv, {29'h0, code});
      rd(OFS_RELOAD);
      check_val(rdv, {20'h0, reload_field});
   endtask : setup

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      clk               = 1'b0;
      ls_clk            = 1'b0;
      reset_n           = 1'b0;
      hw_enable_option  = 1'b0;
      core_halted       = 1'b0;
      debug_halt_freeze = 1'b0;
      bus_addr          = 4'h0;
      bus_wdata         = 32'h0;
      bus_wr            = 1'b0;
      bus_rd            = 1'b0;
      fail_count        = 0;
      num_checks        = 0;
      cycles            = 0;
      ls_edges          = 0;
      // Timeout for every prescaler code
      foreach (rows[i])
      begin
         do_reset(1'b0);
         setup(rows[i].code, rows[i].reload_field);
         t_exp = rows[i].ticks;
         wr(OFS_KEY_COMMAND, {16'h0, KEY_ENABLE});
         ls_edges = 0;
         for (int k = 0; k < (t_exp + 4) * 10; k++)
         begin
            @(posedge clk);
            if (system_reset_req === 1'b1)
               break;
         end
         check_val(system_reset_req === 1'b1 && ls_edges >= t_exp - 1
                   && ls_edges <= t_exp + 1, 1'b1);
      end
      // Reset values, unmapped read, protection
      do_reset(1'b0);
      check_val({system_reset_req, watchdog_enabled, counter_value}, 14'h0FFF);
      foreach (raddr[i])
      begin
         rd(raddr[i]);
         check_val(rdv, rexp[i]);
      end
      wr(OFS_RELOAD, 32'h0000_0123);
      rd(OFS_RELOAD);
      check_val(rdv, 32'h0000_0FFF);
      wr(OFS_KEY_COMMAND, {16'h0, KEY_UNLOCK});
      wr(OFS_KEY_COMMAND, 32'h0000_1234);
      wr(OFS_RELOAD, 32'h0000_0123);
      rd(OFS_RELOAD);
      check_val(rdv, 32'h0000_0FFF);
      wr(OFS_KEY_COMMAND, {16'h0, KEY_UNLOCK});
      wr(OFS_KEY_COMMAND, {16'h0, KEY_RELOAD});
      wr(OFS_PRESCALER, 32'h0000_0005);
      rd(OFS_PRESCALER);
      check_val(rdv, 32'h0);
      wr(OFS_KEY_COMMAND, {16'h0, KEY_UNLOCK});
      wr(OFS_RELOAD, 32'h0000_0123);
      rd(OFS_STATUS);
      check_val(rdv, 32'h0000_0002);
      wait_idle();
      wr(OFS_KEY_COMMAND, {16'h0, KEY_UNLOCK});
      wr(OFS_PRESCALER, 32'h0000_0005);
      rd(OFS_STATUS);
      check_val(rdv, 32'h0000_0001);
      wait_idle();
      // Enable load, debug freeze, periodic reload
      do_reset(1'b0);
      setup(3'h0, 12'h00F);
      wr(OFS_KEY_COMMAND, {16'h0, KEY_ENABLE});
      check_val(counter_value, 12'h00F);
      @(posedge clk);
      core_halted       <= 1'b1;
      debug_halt_freeze <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      c0 = counter_value;
      repeat (200) @(posedge clk);
      #1;
      check_val({system_reset_req, counter_value}, {1'b0, c0});
      @(posedge clk);
      debug_halt_freeze <= 1'b0;
      repeat (100) @(posedge clk);
      #1;
      check_val(counter_value !== c0, 1'b1);
      @(posedge clk);
      core_halted <= 1'b0;
      wr(OFS_KEY_COMMAND, {16'h0, KEY_RELOAD});
      check_val(counter_value, 12'h00F);
      repeat (6)
      begin
         repeat (100) @(posedge clk);
         wr(OFS_KEY_COMMAND, {16'h0, KEY_RELOAD});
      end
      check_val(system_reset_req, 1'b0);
      wr(OFS_KEY_COMMAND, 32'h0000_1234);
      rd(OFS_KEY_COMMAND);
      check_val({watchdog_enabled, rdv}, {1'b1, 32'h0});
      // Hardware enable option
      do_reset(1'b1);
      @(posedge clk);
      #1;
      check_val(watchdog_enabled, 1'b1);
      repeat (100) @(posedge clk);
      wr(OFS_KEY_COMMAND, {16'h0, KEY_ENABLE});
      check_val(counter_value !== 12'hFFF, 1'b1);
      summarize();
   end
endmodule : independent_watchdog_tb_top
